// ---- test/cids_decoder_tb.sv ----
// Self-checking bench for the instruction decoder
module cids_decoder_tb
    import cids_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk;
    logic        rst_n;
    wire         fetch_valid;
    wire  [31:0] fetch_word;
    cids_kind_t  dec_kind_ff;
    logic        dec_valid_ff, dec_len4_ff, dec_illegal_ff;
    logic [3:0]  dec_reg_a_ff, dec_reg_b_ff;
    logic [15:0] dec_ext_ff;
    logic        dec_byte_ff, dec_sub_ff, dec_carry_ff, dec_unsigned_ff, dec_div_wide_ff;
    logic        dec_negate_ff, dec_bit_invert_ff, dec_flags_only_ff, dec_field_high_ff;
    logic        dec_sign_fill_ff, dec_zero_ext_ff, dec_step_inc_ff, dec_jump_on_set_ff;
    logic        dec_bit_modify_ff, dec_push_first_ff, dec_pop_reg_ff, dec_nop_ff;
    logic [1:0]  dec_step_amt_ff, dec_mac_op_ff;
    logic        dec_in_prefix_ff, pfx_segment_ff, pfx_regext_ff;
    int          fails;
    int          n_tests;
    int          pfx_left;

    wire  [20:0] got_int = {dec_byte_ff, dec_sub_ff, dec_carry_ff, dec_unsigned_ff,
        dec_div_wide_ff, dec_negate_ff, dec_bit_invert_ff, dec_flags_only_ff,
        dec_field_high_ff, dec_sign_fill_ff, dec_zero_ext_ff, dec_step_inc_ff, dec_step_amt_ff,
        dec_jump_on_set_ff, dec_bit_modify_ff, dec_push_first_ff, dec_pop_reg_ff, dec_nop_ff,
        dec_mac_op_ff};

    // Allowed lengths by kind code: bit 0 two bytes, bit 1 four bytes
    localparam logic [1:0] ALLOW_MAP [21] = '{
        2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2,
        2'h2, 2'h3, 2'h1, 2'h1, 2'h3, 2'h2, 2'h2, 2'h2,
        2'h1, 2'h1, 2'h2, 2'h3, 2'h2
    };

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    cids_fetch_model fetch_u (.ref_clk, .fetch_valid, .fetch_word);

    cids_decoder dut_u (
        .ref_clk, .rst_n, .fetch_valid, .fetch_word,
        .dec_valid_ff, .dec_kind_ff, .dec_len4_ff, .dec_illegal_ff,
        .dec_reg_a_ff, .dec_reg_b_ff, .dec_ext_ff,
        .dec_byte_ff, .dec_sub_ff, .dec_carry_ff, .dec_unsigned_ff, .dec_div_wide_ff,
        .dec_negate_ff, .dec_bit_invert_ff, .dec_flags_only_ff, .dec_field_high_ff,
        .dec_sign_fill_ff, .dec_zero_ext_ff, .dec_step_inc_ff, .dec_step_amt_ff,
        .dec_jump_on_set_ff, .dec_bit_modify_ff, .dec_push_first_ff, .dec_pop_reg_ff,
        .dec_nop_ff, .dec_mac_op_ff, .dec_in_prefix_ff, .pfx_segment_ff, .pfx_regext_ff
    );

    function automatic logic exp_ok(input logic [31:0] w);
        return (w[7:3] <= 5'h14) && ALLOW_MAP[w[7:3]][w[0]];
    endfunction

    // Kind codes follow the package enumeration
    function automatic logic [20:0] exp_intent(input logic [31:0] w);
        logic [4:0]  k;
        logic        v1;
        logic        v0;
        logic [20:0] e;
        k      = w[7:3];
        v1     = w[2];
        v0     = w[1];
        e[20]  = (k == 5'h01) || (k == 5'h05) || (k == 5'h0C);
        e[19]  = (k <= 5'h01) && v0;
        e[18]  = (k <= 5'h01) && v1;
        e[17]  = (k == 5'h02 || k == 5'h03) && v0;
        e[16]  = (k == 5'h03) && v1;
        e[15]  = (k == 5'h04 || k == 5'h05) && v0;
        e[14]  = (k == 5'h06) && v0;
        e[13]  = (k == 5'h07);
        e[12]  = (k == 5'h08) && v0;
        e[11]  = (k == 5'h0B);
        e[10]  = (k == 5'h0C) && v0;
        e[9]   = (k == 5'h09) && v0;
        e[8:7] = (k == 5'h09) ? (v1 ? 2'h2 : 2'h1) : 2'h0;
        e[6]   = (k == 5'h0D) && !v0;
        e[5]   = (k == 5'h0D) && v1;
        e[4]   = (k == 5'h0E) || (k == 5'h0F);
        e[3]   = (k == 5'h11) && v0;
        e[2]   = (k == 5'h12);
        e[1:0] = (k == 5'h14) ? {v1, v0} : 2'h0;
        return exp_ok(w) ? e : 21'h000000;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Sends one word and judges the decode that appears one edge later
    task automatic send_chk(input logic [31:0] w);
        logic        ok;
        logic        inp;
        logic [20:0] e;
        ok  = exp_ok(w);
        inp = ok && (w[7:3] != 5'h13) && (pfx_left != 0);
        e   = exp_intent(w);
        fetch_u.issue(w);
        chk(32'({dec_valid_ff, !dec_illegal_ff, dec_len4_ff, dec_kind_ff}),
            32'({1'b1, ok, w[0], w[7:3]}));
        chk(32'(got_int[20:15]), 32'(e[20:15]));
        chk(32'(got_int[14:12]), 32'(e[14:12]));
        chk(32'(got_int[9:7]), 32'(e[9:7]));
        chk(32'(got_int[11:10]), 32'(e[11:10]));
        chk(32'(got_int[6:3]), 32'(e[6:3]));
        chk(32'(got_int[2]), 32'(e[2]));
        chk(32'(got_int[1:0]), 32'(e[1:0]));
        if (ok)
            chk({dec_ext_ff, dec_reg_a_ff, dec_reg_b_ff, 8'h00}, {w[31:8], 8'h00});
        chk(32'(dec_in_prefix_ff), 32'(inp));
        // Outside a sequence, or on the word that ends it, the prefix levels must be low
        if (!(ok && w[7:3] == 5'h13) && (pfx_left == 0 || (ok && pfx_left == 1)))
            chk(32'({pfx_segment_ff, pfx_regext_ff}), 32'h0);
        if (ok && w[7:3] == 5'h13)
            chk(32'({pfx_segment_ff, pfx_regext_ff}), 32'({w[1], w[2]}));
        if (ok && w[7:3] == 5'h13)
            pfx_left = int'(w[9:8]) + 1;
        else if (ok && pfx_left > 0)
            pfx_left--;
    endtask

    // Every kind code with every variant and length, back to back
    task automatic t_sweep();
        for (int k = 0; k < 32; k++) begin
            for (int j = 0; j < 8; j++) begin
                send_chk({8'(k * 13 + j), 8'(255 - k), 4'(j + k), 4'(k), 5'(k), 3'(j)});
            end
        end
    endtask

    // Prefix counts, illegal words inside a sequence, a gap, and a restarting prefix
    task automatic t_prefix();
        fetch_u.idle();
        send_chk(32'h0000_019E);
        send_chk(32'h0000_00F8);
        send_chk(32'h0000_0011);
        fetch_u.idle();
        chk(32'(dec_valid_ff), 32'h0);
        send_chk(32'h0000_1203);
        send_chk(32'h0000_3400);
        send_chk(32'h0000_0000);
        send_chk(32'h0000_0098);
        send_chk(32'h0000_009B);
        send_chk(32'h0000_0092);
        send_chk(32'h0000_0000);
    endtask

    // Reset in mid-sequence must drop the prefix state
    task automatic t_reset_mid();
        send_chk(32'h0000_0298);
        send_chk(32'h0000_0000);
        fetch_u.idle();
        rst_n = 1'b0;
        @(posedge ref_clk);
        @(posedge ref_clk);
        #1;
        chk(32'({dec_valid_ff, dec_in_prefix_ff, pfx_segment_ff, pfx_regext_ff}), 32'h0);
        rst_n    = 1'b1;
        pfx_left = 0;
        send_chk(32'h0000_0000);
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; this leaves ample margin
    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end

    initial begin
        fails    = 0;
        n_tests  = 0;
        pfx_left = 0;
        rst_n    = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        t_sweep();
        t_prefix();
        t_reset_mid();
        tally_and_finish();
    end
endmodule

// ---- test/cids_fetch_model.sv ----
// Behavioural fetch stage that feeds the decoder one instruction word per cycle
module cids_fetch_model (
    // Clock
    input  wire logic        ref_clk,
    // Fetch side
    output logic             fetch_valid,
    output logic [31:0]      fetch_word
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        fetch_valid = 1'b0;
        fetch_word  = 32'h0000_0000;
    end

    // Caller sits just after an edge; the word is taken at the next edge
    task automatic issue(input logic [31:0] w);
        fetch_valid = 1'b1;
        fetch_word  = w;
        @(posedge ref_clk);
        #1;
    endtask

    // A released word shows the inverse of the last one, so stale data cannot pass
    task automatic idle();
        fetch_valid = 1'b0;
        fetch_word  = ~fetch_word;
        @(posedge ref_clk);
        #1;
    endtask
endmodule

// ---- verilog/cids_decoder.sv ----
// Instruction decoder: classifies fetched words and registers execution intent
// What this block does
// - Add/subtract word or byte, carry, 2/4 bytes
// - Register multiply, signed or unsigned, 2 bytes
// - Short divide of low register, 2 bytes
// - Long divide of full pair, 2 bytes
// - Complement or negate register, word/byte, 2 bytes
// - Bit move, optional inversion, 4 bytes
// - Bit compare sets flags only, 4 bytes
// - Masked high/low byte field modify, 4 bytes
// - Compare then step register by 1/2
// - Normalisation count into register, 2 bytes
// - Sign-filling right shift, 2 bytes
// - Byte to word, sign/zero extension, 2/4
// - Bit test jumps with optional bit modify
// - Push register then absolute call, 4 bytes
// - Push register then load it, 4 bytes
// - Trap by immediate number, 2 bytes
// - Near return, optional register pop, 2 bytes
// - Legacy power-down decodes as 4-byte no-op
// - Page/segment prefixes start sequences, 2/4 bytes
// - Coprocessor operations all decode as 4 bytes
module cids_decoder
    import cids_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // From fetch
    input  wire logic        fetch_valid,
    input  wire logic [31:0] fetch_word,
    // Decode result
    output logic             dec_valid_ff,
    output cids_kind_t       dec_kind_ff,
    output logic             dec_len4_ff,
    output logic             dec_illegal_ff,
    output logic [3:0]       dec_reg_a_ff,
    output logic [3:0]       dec_reg_b_ff,
    output logic [15:0]      dec_ext_ff,
    // Arithmetic intent
    output logic             dec_byte_ff,
    output logic             dec_sub_ff,
    output logic             dec_carry_ff,
    output logic             dec_unsigned_ff,
    output logic             dec_div_wide_ff,
    output logic             dec_negate_ff,
    // Bit and shift intent
    output logic             dec_bit_invert_ff,
    output logic             dec_flags_only_ff,
    output logic             dec_field_high_ff,
    output logic             dec_sign_fill_ff,
    output logic             dec_zero_ext_ff,
    // Compare-and-step intent
    output logic             dec_step_inc_ff,
    output logic [1:0]       dec_step_amt_ff,
    // Flow intent
    output logic             dec_jump_on_set_ff,
    output logic             dec_bit_modify_ff,
    output logic             dec_push_first_ff,
    output logic             dec_pop_reg_ff,
    output logic             dec_nop_ff,
    output logic [1:0]       dec_mac_op_ff,
    // Prefix sequence state
    output logic             dec_in_prefix_ff,
    output logic             pfx_segment_ff,
    output logic             pfx_regext_ff
);

    // Map lookup
    cids_kind_t in_kind;
    logic       in_len4;
    logic       in_legal;

    cids_opmap u_opmap (
        .opcode (fetch_word[OPC_MSB:OPC_LSB]),
        .kind   (in_kind),
        .len4   (in_len4),
        .legal  (in_legal)
    );

    wire        var0 = fetch_word[VAR0_BIT];
    wire        var1 = fetch_word[VAR1_BIT];
    wire        take = fetch_valid && in_legal;

    wire        is_add   = take && (in_kind == KIND_ADD_WORD || in_kind == KIND_ADD_BYTE);
    wire        is_mult  = take && in_kind == KIND_MULTIPLY;
    wire        is_div   = take && in_kind == KIND_DIVIDE;
    wire        is_compl = take && (in_kind == KIND_COMPLEMENT_WORD ||
                                    in_kind == KIND_COMPLEMENT_BYTE);
    wire        is_bmove = take && in_kind == KIND_BIT_MOVE;
    wire        is_bcmp  = take && in_kind == KIND_BIT_COMPARE;
    wire        is_field = take && in_kind == KIND_FIELD_MODIFY;
    wire        is_step  = take && in_kind == KIND_COMPARE_STEP;
    wire        is_shift = take && in_kind == KIND_ARITH_SHIFT;
    wire        is_widen = take && in_kind == KIND_BYTE_WIDEN;
    wire        is_jbit  = take && in_kind == KIND_JUMP_BIT;
    wire        is_push_and_call_op = take && in_kind == KIND_PUSH_CALL;
    wire        is_cswch = take && in_kind == KIND_CONTEXT_SWITCH;
    wire        is_ret   = take && in_kind == KIND_NEAR_RETURN;
    wire        is_pwrd  = take && in_kind == KIND_LEGACY_PWRDOWN;
    wire        is_pfx   = take && in_kind == KIND_PREFIX;
    wire        is_mac   = take && in_kind == KIND_MAC;

    // Intent flags; an illegal opcode leaves every flag low
    wire        nxt_byte      = (is_add && in_kind == KIND_ADD_BYTE) ||
                                (is_compl && in_kind == KIND_COMPLEMENT_BYTE) ||
                                is_widen;
    wire        nxt_sub       = is_add && var0;
    wire        nxt_carry     = is_add && var1;
    wire        nxt_unsigned  = (is_mult || is_div) && var0;
    // Long form divides the 32-bit pair, short form only the low half
    wire        nxt_div_wide  = is_div && var1;
    wire        nxt_negate    = is_compl && var0;
    wire        nxt_invert    = is_bmove && var0;
    wire        nxt_flags     = is_bcmp;
    wire        nxt_fld_high  = is_field && var0;
    wire        nxt_sign_fill = is_shift;
    wire        nxt_zero_ext  = is_widen && var0;
    wire        nxt_step_inc  = is_step && var0;
    wire [1:0]  nxt_step_amt  = !is_step ? 2'h0 : (var1 ? STEP_TWO : STEP_ONE);
    wire        nxt_jump_set  = is_jbit && !var0;
    wire        nxt_bit_mod   = is_jbit && var1;
    wire        nxt_push      = is_push_and_call_op || is_cswch;
    wire        nxt_pop       = is_ret && var0;
    // Power-down is kept in the map so fetch advances 4 bytes, but does nothing
    wire        nxt_nop       = is_pwrd;
    wire [1:0]  nxt_mac_op    = is_mac ? {var1, var0} : MAC_ARITH;

    // Prefix sequence tracking
    cids_pfx_t  pfx_state_ff;
    cids_pfx_t  nxt_pfx_state;
    logic [2:0] pfx_left_ff;
    logic [2:0] nxt_pfx_left;
    logic       nxt_pfx_seg;
    logic       nxt_pfx_reg;

    wire        pfx_consume = take && !is_pfx && pfx_state_ff == PS_ACTIVE;
    wire [2:0]  pfx_load    = 3'(fetch_word[PFX_CNT_MSB:PFX_CNT_LSB]) + PFX_CNT_ONE;

    always_comb begin
        nxt_pfx_state = pfx_state_ff;
        nxt_pfx_left  = pfx_left_ff;
        nxt_pfx_seg   = pfx_segment_ff;
        nxt_pfx_reg   = pfx_regext_ff;
        case (pfx_state_ff)
            PS_IDLE: begin
                if (is_pfx) begin
                    nxt_pfx_state = PS_ACTIVE;
                    nxt_pfx_left  = pfx_load;
                    nxt_pfx_seg   = var0;
                    nxt_pfx_reg   = var1;
                end
            end
            PS_ACTIVE: begin
                // A new prefix restarts the sequence rather than nesting
                if (is_pfx) begin
                    nxt_pfx_left = pfx_load;
                    nxt_pfx_seg  = var0;
                    nxt_pfx_reg  = var1;
                end else if (pfx_consume) begin
                    nxt_pfx_left = pfx_left_ff - PFX_CNT_ONE;
                    if (pfx_left_ff == PFX_CNT_ONE) begin
                        nxt_pfx_state = PS_IDLE;
                        nxt_pfx_seg   = 1'b0;
                        nxt_pfx_reg   = 1'b0;
                    end
                end
            end
            default: begin
                nxt_pfx_state = PS_IDLE;
                nxt_pfx_left  = 3'h0;
                nxt_pfx_seg   = 1'b0;
                nxt_pfx_reg   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pfx_state_ff   <= PS_IDLE;
            pfx_left_ff    <= 3'h0;
            pfx_segment_ff <= 1'b0;
            pfx_regext_ff  <= 1'b0;
        end else begin
            pfx_state_ff   <= nxt_pfx_state;
            pfx_left_ff    <= nxt_pfx_left;
            pfx_segment_ff <= nxt_pfx_seg;
            pfx_regext_ff  <= nxt_pfx_reg;
        end
    end

    // Classification and operand capture
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dec_valid_ff     <= 1'b0;
            dec_kind_ff      <= KIND_ADD_WORD;
            dec_len4_ff      <= 1'b0;
            dec_illegal_ff   <= 1'b0;
            dec_reg_a_ff     <= 4'h0;
            dec_reg_b_ff     <= 4'h0;
            dec_ext_ff       <= 16'h0000;
            dec_in_prefix_ff <= 1'b0;
        end else begin
            dec_valid_ff     <= fetch_valid;
            dec_kind_ff      <= in_kind;
            dec_len4_ff      <= in_len4;
            dec_illegal_ff   <= fetch_valid && !in_legal;
            dec_reg_a_ff     <= fetch_word[REG_A_MSB:REG_A_LSB];
            dec_reg_b_ff     <= fetch_word[REG_B_MSB:REG_B_LSB];
            dec_ext_ff       <= fetch_word[EXT_MSB:EXT_LSB];
            dec_in_prefix_ff <= pfx_consume;
        end
    end

    // Intent flags; the trap number and the normalise target ride in the operand fields
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dec_byte_ff        <= 1'b0;
            dec_sub_ff         <= 1'b0;
            dec_carry_ff       <= 1'b0;
            dec_unsigned_ff    <= 1'b0;
            dec_div_wide_ff    <= 1'b0;
            dec_negate_ff      <= 1'b0;
            dec_bit_invert_ff  <= 1'b0;
            dec_flags_only_ff  <= 1'b0;
            dec_field_high_ff  <= 1'b0;
            dec_sign_fill_ff   <= 1'b0;
            dec_zero_ext_ff    <= 1'b0;
            dec_step_inc_ff    <= 1'b0;
            dec_step_amt_ff    <= 2'h0;
            dec_jump_on_set_ff <= 1'b0;
            dec_bit_modify_ff  <= 1'b0;
            dec_push_first_ff  <= 1'b0;
            dec_pop_reg_ff     <= 1'b0;
            dec_nop_ff         <= 1'b0;
            dec_mac_op_ff      <= MAC_ARITH;
        end else begin
            dec_byte_ff        <= nxt_byte;
            dec_sub_ff         <= nxt_sub;
            dec_carry_ff       <= nxt_carry;
            dec_unsigned_ff    <= nxt_unsigned;
            dec_div_wide_ff    <= nxt_div_wide;
            dec_negate_ff      <= nxt_negate;
            dec_bit_invert_ff  <= nxt_invert;
            dec_flags_only_ff  <= nxt_flags;
            dec_field_high_ff  <= nxt_fld_high;
            dec_sign_fill_ff   <= nxt_sign_fill;
            dec_zero_ext_ff    <= nxt_zero_ext;
            dec_step_inc_ff    <= nxt_step_inc;
            dec_step_amt_ff    <= nxt_step_amt;
            dec_jump_on_set_ff <= nxt_jump_set;
            dec_bit_modify_ff  <= nxt_bit_mod;
            dec_push_first_ff  <= nxt_push;
            dec_pop_reg_ff     <= nxt_pop;
            dec_nop_ff         <= nxt_nop;
            dec_mac_op_ff      <= nxt_mac_op;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    wire [4:0] raw_kind = fetch_word[KIND_MSB:KIND_LSB];

    a_add_carry_form: assert property (
        is_add |=> dec_valid_ff && !dec_illegal_ff &&
                   dec_carry_ff == $past(var1) && dec_sub_ff == $past(var0))
        else $error("add/subtract intent not captured");

    a_multiply_short: assert property (
        fetch_valid && raw_kind == KIND_MULTIPLY && fetch_word[LONG_BIT]
        |=> dec_illegal_ff && !dec_unsigned_ff)
        else $error("4-byte multiply accepted");

    a_divide_short: assert property (
        is_div && !var1 |=> !dec_div_wide_ff && !dec_len4_ff && !dec_illegal_ff)
        else $error("short divide decoded as long");

    a_divide_long: assert property (
        is_div && var1 |=> dec_div_wide_ff && dec_kind_ff == KIND_DIVIDE)
        else $error("long divide lost its wide dividend");

    a_compl_byte: assert property (
        is_compl && in_kind == KIND_COMPLEMENT_BYTE |=> dec_byte_ff && !dec_len4_ff)
        else $error("byte complement width wrong");

    a_bit_move_len: assert property (
        fetch_valid && raw_kind == KIND_BIT_MOVE && !fetch_word[LONG_BIT]
        |=> dec_illegal_ff && !dec_bit_invert_ff)
        else $error("2-byte bit move accepted");

    a_bit_compare_only: assert property (
        is_bcmp |=> dec_flags_only_ff && dec_len4_ff && !dec_illegal_ff && !dec_bit_invert_ff)
        else $error("bit compare not flags-only");

    a_field_half: assert property (
        is_field |=> dec_field_high_ff == $past(var0) && dec_len4_ff)
        else $error("field modify half wrong");

    a_step_amount: assert property (
        is_step |=> dec_step_amt_ff == ($past(var1) ? STEP_TWO : STEP_ONE) &&
                    dec_step_inc_ff == $past(var0))
        else $error("compare step amount wrong");

    a_pwrdown_noop: assert property (
        is_pwrd |=> dec_nop_ff && dec_len4_ff && !dec_push_first_ff && !dec_illegal_ff)
        else $error("legacy power-down not a 4-byte no-op");

    a_short_operands: assert property (
        take && (in_kind == KIND_NORMALIZE || in_kind == KIND_TRAP)
        |=> !dec_len4_ff && dec_reg_a_ff == $past(fetch_word[REG_A_MSB:REG_A_LSB]) &&
            dec_reg_b_ff == $past(fetch_word[REG_B_MSB:REG_B_LSB]))
        else $error("short operand capture wrong");

    a_prefix_single: assert property (
        is_pfx && fetch_word[PFX_CNT_MSB:PFX_CNT_LSB] == 2'h0 ##1 take && !is_pfx
        |=> dec_in_prefix_ff && pfx_state_ff == PS_IDLE)
        else $error("prefix sequence length wrong");

    a_mac_four: assert property (
        fetch_valid && raw_kind == KIND_MAC |=> dec_illegal_ff == !$past(fetch_word[LONG_BIT]))
        else $error("coprocessor length check wrong");

    a_map_illegal: assert property (
        fetch_valid && !in_legal |=> dec_valid_ff && dec_illegal_ff && dec_mac_op_ff == MAC_ARITH)
        else $error("unmapped opcode not flagged");

endmodule

// ---- verilog/cids_opmap.sv ----
// Opcode map lookup: kind, length and legality of one opcode byte
module cids_opmap
    import cids_pkg::*;
(
    // Opcode in
    input  wire logic [7:0] opcode,
    // Decoded map entry
    output cids_kind_t      kind,
    output logic            len4,
    output logic            legal
);

    wire [KIND_COUNT-1:0] hit;

    // One comparator per map entry; length bit must match an allowed form
    genvar k;
    generate
        for (k = 0; k < KIND_COUNT; k++) begin : g_entry
            assign hit[k] = (opcode[KIND_MSB:KIND_LSB] == 5'(k)) &&
                            (opcode[LONG_BIT] ? LEN_ALLOW[k][1] : LEN_ALLOW[k][0]);
        end
    endgenerate

    assign kind  = cids_kind_t'(opcode[KIND_MSB:KIND_LSB]);
    assign len4  = opcode[LONG_BIT];
    assign legal = |hit;

endmodule

// ---- verilog/cids_pkg.sv ----
// Shared constants and types for the instruction decode block
package cids_pkg;

    // Instruction word layout: opcode byte, operand byte, extension word
    localparam int OPC_LSB       = 0;
    localparam int OPC_MSB       = 7;
    localparam int KIND_LSB      = 3;
    localparam int KIND_MSB      = 7;
    localparam int VAR1_BIT      = 2;
    localparam int VAR0_BIT      = 1;
    localparam int LONG_BIT      = 0;
    localparam int REG_A_LSB     = 12;
    localparam int REG_A_MSB     = 15;
    localparam int REG_B_LSB     = 8;
    localparam int REG_B_MSB     = 11;
    localparam int PFX_CNT_LSB   = 8;
    localparam int PFX_CNT_MSB   = 9;
    localparam int EXT_LSB       = 16;
    localparam int EXT_MSB       = 31;
    localparam int KIND_COUNT    = 32;

    // Encoded lengths allowed per kind: bit 0 = 2 bytes, bit 1 = 4 bytes
    localparam logic [1:0] LEN_NONE = 2'h0;
    localparam logic [1:0] LEN_2    = 2'h1;
    localparam logic [1:0] LEN_4    = 2'h2;
    localparam logic [1:0] LEN_24   = 2'h3;

    localparam logic [1:0] STEP_ONE = 2'h1;
    localparam logic [1:0] STEP_TWO = 2'h2;

    localparam logic [1:0] MAC_ARITH = 2'h0;
    localparam logic [1:0] MAC_LOAD  = 2'h1;
    localparam logic [1:0] MAC_STORE = 2'h2;

    localparam logic [2:0] PFX_CNT_ONE = 3'h1;

    typedef enum logic [4:0] {
        KIND_ADD_WORD        = 5'h00,
        KIND_ADD_BYTE        = 5'h01,
        KIND_MULTIPLY        = 5'h02,
        KIND_DIVIDE          = 5'h03,
        KIND_COMPLEMENT_WORD = 5'h04,
        KIND_COMPLEMENT_BYTE = 5'h05,
        KIND_BIT_MOVE        = 5'h06,
        KIND_BIT_COMPARE     = 5'h07,
        KIND_FIELD_MODIFY    = 5'h08,
        KIND_COMPARE_STEP    = 5'h09,
        KIND_NORMALIZE       = 5'h0A,
        KIND_ARITH_SHIFT     = 5'h0B,
        KIND_BYTE_WIDEN      = 5'h0C,
        KIND_JUMP_BIT        = 5'h0D,
        KIND_PUSH_CALL       = 5'h0E,
        KIND_CONTEXT_SWITCH  = 5'h0F,
        KIND_TRAP            = 5'h10,
        KIND_NEAR_RETURN     = 5'h11,
        KIND_LEGACY_PWRDOWN  = 5'h12,
        KIND_PREFIX          = 5'h13,
        KIND_MAC             = 5'h14
    } cids_kind_t;

    // Opcode map: allowed lengths indexed by kind code
    localparam logic [1:0] LEN_ALLOW [KIND_COUNT] = '{
        LEN_24, LEN_24, LEN_2,  LEN_2,  LEN_2,  LEN_2,  LEN_4,  LEN_4,
        LEN_4,  LEN_24, LEN_2,  LEN_2,  LEN_24, LEN_4,  LEN_4,  LEN_4,
        LEN_2,  LEN_2,  LEN_4,  LEN_24, LEN_4,  LEN_NONE, LEN_NONE, LEN_NONE,
        LEN_NONE, LEN_NONE, LEN_NONE, LEN_NONE, LEN_NONE, LEN_NONE, LEN_NONE, LEN_NONE
    };

    typedef enum logic [1:0] {
        PS_IDLE   = 2'b01,
        PS_ACTIVE = 2'b10
    } cids_pfx_t;

endpackage
